// [avca_pkg.sv]
// Constants for the AAL2 voice channel assembly control block.
// Assumes a 32-bit AXI4-Lite register bus and a 12-bit byte address.
package avca_pkg;
  localparam int unsigned AVCA_AW = 12;
  // Register byte offsets
  localparam logic [11:0] AVCA_CTRL = 12'h000;
  localparam logic [11:0] AVCA_NEXT_BYTE = 12'h004;
  localparam logic [11:0] AVCA_SS_PTR = 12'h008;
  localparam logic [11:0] AVCA_SPP_LO = 12'h00C;
  localparam logic [11:0] AVCA_SEQ_CFG = 12'h010;
  localparam logic [11:0] AVCA_TS_OFFSET = 12'h014;
  localparam logic [11:0] AVCA_SEQ_STATE = 12'h018;
  localparam logic [11:0] AVCA_TS_REM = 12'h01C;
  localparam logic [11:0] AVCA_WRAP_INC = 12'h020;
  localparam logic [11:0] AVCA_PKT_COUNT = 12'h024;
  localparam logic [11:0] AVCA_BEARER_BASE = 12'h400;
  // CTRL field positions
  localparam int unsigned AVCA_VALID_BIT = 0;
  localparam int unsigned AVCA_INIT_BIT = 1;
  localparam int unsigned AVCA_BUFSZ_LSB = 8;
  localparam int unsigned AVCA_BEARER_LSB = 16;
  localparam int unsigned AVCA_XDELAY_LSB = 24;
  // SEQ_CFG field positions
  localparam int unsigned AVCA_SEQBITS_LSB = 8;
  localparam int unsigned AVCA_INTERVAL_LSB = 16;
  // Buffer size codes
  localparam logic [2:0] AVCA_BUF_256 = 3'h0;
  localparam logic [2:0] AVCA_BUF_512 = 3'h1;
  localparam logic [8:0] AVCA_MASK_256 = 9'h0FF;
  localparam logic [8:0] AVCA_MASK_512 = 9'h1FF;
  // Codec rates and sequence width
  localparam int unsigned AVCA_NUM_RATES = 5;
  localparam logic [2:0] AVCA_MAX_RATE = 3'h4;
  localparam logic [2:0] AVCA_MAX_SEQBITS = 3'h4;
  // Silence suppression structure granule is 32 bytes
  localparam int unsigned AVCA_SS_SHIFT = 5;
  // Circular buffer base granule is 512 bytes
  localparam int unsigned AVCA_BASE_SHIFT = 9;
  // Divider steps for a 33-bit dividend
  localparam logic [5:0] AVCA_DIV_STEPS = 6'h21;
  // AXI responses
  localparam logic [1:0] AVCA_RESP_OKAY = 2'h0;
  localparam logic [1:0] AVCA_RESP_SLVERR = 2'h2;
  // Reset values
  localparam logic [31:0] AVCA_RST_WORD = 32'h0000_0000;
  localparam logic [15:0] AVCA_RST_HALF = 16'h0000;
endpackage : avca_pkg

// [avca_bearer_mem.sv]
// Bearer circular buffer base address table, 256 words of 16 bits.
// Assumes one writer and one reader on the same clock; read is registered.
`timescale 1ns/1ps
module avca_bearer_mem (
  // Clock
  input wire logic aclk,
  // Write port
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [15:0] wr_data,
  // Read port
  input wire logic rd_en,
  input wire logic [7:0] rd_addr,
  output logic [15:0] rd_data
);
  logic [15:0] mem [0:255];

  always_ff @(posedge aclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule : avca_bearer_mem

// [avca_channel_ctl.sv]
// Control of one voice channel over a transmit AAL2 connection.
// Assumes scheduler events, TDM pointer and timestamp on the aclk domain.
//
// Overview of operation
// - Valid flag low: every service event is dropped, no packet sent.
// - Zero silence suppression pointer disables silence suppression.
// - Nonzero pointer addresses first SRAM bank in 32-byte units.
// - Each frame reads one sample from every configured bearer buffer.
// - Bearer count fixes how many base address words are used.
// - Per-rate samples per packet; total is bearer count times it.
// - Sequence width selects UUI sequence bits, zero to four.
// - Sequence interval gives frames per increment, 1 to 255.
// - Sequence is timestamp over interval, modulo two to the width.
// - Init set by first start event; packets only while init is one.
// - First start event sends nothing, adds write pointer to next byte.
// - Buffer code 000 is 256 samples, 001 is 512, others reserved.
`timescale 1ns/1ps
module avca_channel_ctl
  import avca_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [AVCA_AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [AVCA_AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Scheduler service events
  input wire logic ev_valid,
  output logic ev_ready,
  input wire logic ev_start_indication,
  input wire logic [2:0] ev_rate,
  // TDM side state
  input wire logic [15:0] tdm_wr_ptr,
  input wire logic [31:0] bus_timestamp,
  // Packet descriptor to CPS transmitter
  output logic pkt_valid,
  input wire logic pkt_ready,
  output logic [15:0] pkt_samples,
  output logic [3:0] pkt_uui_seq,
  output logic [2:0] pkt_rate,
  output logic pkt_ss_enable,
  output logic [20:0] pkt_ss_addr,
  // Sample reads from circular buffers
  output logic smp_valid,
  input wire logic smp_ready,
  output logic [24:0] smp_addr,
  output logic smp_last
);
  typedef enum logic [2:0] {
    S_IDLE, S_EVAL, S_DIV, S_PKT, S_LOOK, S_SMP
  } avca_state_t;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [8:0] buf_mask(input logic [2:0] code);
    return (code == AVCA_BUF_512) ? AVCA_MASK_512 : AVCA_MASK_256;
  endfunction : buf_mask

  avca_state_t state_q;
  logic aw_held_q, w_held_q;
  logic [AVCA_AW-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic wr_fire, wr_map, tbl_wr;
  logic [31:0] ctrl_q, ss_ptr_q, spp_lo_q, seq_cfg_q, ts_off_q, wrap_inc_q;
  logic init_q, seq_t_q;
  logic [15:0] next_byte_q;
  logic [31:0] ts_rem_q, pkt_count_q;
  logic ev_start_q;
  logic [2:0] rate_q;
  logic [15:0] ptr_q;
  logic [31:0] ts_q;
  logic [7:0] div_r_q;
  logic [32:0] div_q;
  logic [5:0] div_cnt_q;
  logic [7:0] frame_q, bearer_q;
  logic [15:0] mem_rdata;
  logic [7:0] bearers, interval, spp;
  logic [2:0] bufsz, seqbits;
  logic ev_take, eval_pkt, wrapped, smp_fire, last_b, last_f;
  logic [32:0] rem_sum;
  logic [11:0] modulus;
  logic [8:0] div_tmp;
  logic [3:0] seq_mask;
  logic [8:0] idx;
  logic [15:0] base_eff;
  logic [31:0] rd_mux;
  logic rd_ok;
  logic [31:0] nb_wr;

  assign bearers = ctrl_q[AVCA_BEARER_LSB +: 8];
  assign bufsz = ctrl_q[AVCA_BUFSZ_LSB +: 3];
  assign seqbits = seq_cfg_q[AVCA_SEQBITS_LSB +: 3];
  assign interval = seq_cfg_q[AVCA_INTERVAL_LSB +: 8];
  assign spp = (rate_q == AVCA_MAX_RATE) ? seq_cfg_q[7:0] :
               spp_lo_q[rate_q[1:0]*8 +: 8];

  // AXI4-Lite write path: address and data taken in either order
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
  assign tbl_wr = wr_fire && awaddr_q[AVCA_AW-1:10] == 2'b01;
  always_comb begin
    wr_map = 1'b1;
    unique case ({awaddr_q[AVCA_AW-1:2], 2'b00})
      AVCA_CTRL, AVCA_NEXT_BYTE, AVCA_SS_PTR, AVCA_SPP_LO, AVCA_SEQ_CFG,
      AVCA_TS_OFFSET, AVCA_SEQ_STATE, AVCA_TS_REM, AVCA_WRAP_INC,
      AVCA_PKT_COUNT: wr_map = 1'b1;
      default: wr_map = awaddr_q[AVCA_AW-1:10] == 2'b01;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= AVCA_RST_WORD;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= AVCA_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_map ? AVCA_RESP_OKAY : AVCA_RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // AXI4-Lite read path
  always_comb begin
    rd_ok = 1'b1;
    rd_mux = AVCA_RST_WORD;
    unique case ({s_axi_araddr[AVCA_AW-1:2], 2'b00})
      AVCA_CTRL: rd_mux = {ctrl_q[31:2], init_q, ctrl_q[0]};
      AVCA_NEXT_BYTE: rd_mux = {16'h0000, next_byte_q};
      AVCA_SS_PTR: rd_mux = ss_ptr_q;
      AVCA_SPP_LO: rd_mux = spp_lo_q;
      AVCA_SEQ_CFG: rd_mux = seq_cfg_q;
      AVCA_TS_OFFSET: rd_mux = ts_off_q;
      AVCA_SEQ_STATE: rd_mux = {31'h0000_0000, seq_t_q};
      AVCA_TS_REM: rd_mux = ts_rem_q;
      AVCA_WRAP_INC: rd_mux = wrap_inc_q;
      AVCA_PKT_COUNT: rd_mux = pkt_count_q;
      default: rd_ok = s_axi_araddr[AVCA_AW-1:10] == 2'b01;
    endcase
  end
  assign s_axi_arready = !rvalid_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= AVCA_RST_WORD;
      rresp_q <= AVCA_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_ok ? AVCA_RESP_OKAY : AVCA_RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // Plain configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= AVCA_RST_WORD;
      ss_ptr_q <= AVCA_RST_WORD;
      spp_lo_q <= AVCA_RST_WORD;
      seq_cfg_q <= AVCA_RST_WORD;
      ts_off_q <= AVCA_RST_WORD;
      wrap_inc_q <= AVCA_RST_WORD;
    end else if (wr_fire) begin
      unique case ({awaddr_q[AVCA_AW-1:2], 2'b00})
        AVCA_CTRL: ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q);
        AVCA_SS_PTR: ss_ptr_q <= merge(ss_ptr_q, wdata_q, wstrb_q);
        AVCA_SPP_LO: spp_lo_q <= merge(spp_lo_q, wdata_q, wstrb_q);
        AVCA_SEQ_CFG: seq_cfg_q <= merge(seq_cfg_q, wdata_q, wstrb_q);
        AVCA_TS_OFFSET: ts_off_q <= merge(ts_off_q, wdata_q, wstrb_q);
        AVCA_WRAP_INC: wrap_inc_q <= merge(wrap_inc_q, wdata_q, wstrb_q);
        default: ;
      endcase
    end
  end

  // Bearer base address table, one word per bearer
  avca_bearer_mem u_mem (
    .aclk(aclk),
    .wr_en(tbl_wr && wstrb_q[1:0] == 2'b11),
    .wr_addr(awaddr_q[9:2]),
    .wr_data(wdata_q[15:0]),
    .rd_en(state_q == S_LOOK),
    .rd_addr(bearer_q),
    .rd_data(mem_rdata)
  );

  // Event sequencing
  assign ev_ready = state_q == S_IDLE;
  assign ev_take = ev_valid && ev_ready;
  assign eval_pkt = ptr_q >= next_byte_q && rate_q <= AVCA_MAX_RATE &&
                    spp != 8'h00 && bearers != 8'h00 && interval != 8'h00;
  assign smp_fire = smp_valid && smp_ready;
  assign last_b = bearer_q == bearers - 8'h01;
  assign last_f = frame_q == spp - 8'h01;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= S_IDLE;
    end else begin
      unique case (state_q)
        S_IDLE: if (ev_take) state_q <= S_EVAL;
        S_EVAL: begin
          if (!ctrl_q[AVCA_VALID_BIT]) begin
            state_q <= S_IDLE;
          end else if (!init_q) begin
            state_q <= S_IDLE;
          end else begin
            state_q <= eval_pkt ? S_DIV : S_IDLE;
          end
        end
        S_DIV: if (div_cnt_q == AVCA_DIV_STEPS) state_q <= S_PKT;
        S_PKT: if (pkt_ready) state_q <= S_LOOK;
        S_LOOK: state_q <= S_SMP;
        S_SMP: if (smp_fire) state_q <= (last_b && last_f) ? S_IDLE : S_LOOK;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ev_start_q <= 1'b0;
      rate_q <= 3'h0;
      ptr_q <= AVCA_RST_HALF;
      ts_q <= AVCA_RST_WORD;
    end else if (ev_take) begin
      ev_start_q <= ev_start_indication;
      rate_q <= ev_rate;
      ptr_q <= tdm_wr_ptr;
      ts_q <= bus_timestamp;
    end
  end

  // Init flag: hardware set wins over a software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      init_q <= 1'b0;
    end else if (state_q == S_EVAL && ctrl_q[AVCA_VALID_BIT] &&
                 !init_q && ev_start_q) begin
      init_q <= 1'b1;
    end else if (wr_fire && awaddr_q == AVCA_CTRL && wstrb_q[0]) begin
      init_q <= wdata_q[AVCA_INIT_BIT];
    end
  end

  // Oldest unsent byte pointer
  assign nb_wr = merge({16'h0000, next_byte_q}, wdata_q, wstrb_q);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      next_byte_q <= AVCA_RST_HALF;
    end else if (state_q == S_EVAL && ctrl_q[AVCA_VALID_BIT] &&
                 !init_q && ev_start_q) begin
      next_byte_q <= next_byte_q + ptr_q;
    end else if (smp_fire && last_b && last_f) begin
      next_byte_q <= next_byte_q + {8'h00, spp};
    end else if (wr_fire && awaddr_q == AVCA_NEXT_BYTE) begin
      next_byte_q <= nb_wr[15:0];
    end
  end

  // Timestamp wrap correction
  assign modulus = {interval, 4'h0};
  assign wrapped = seq_t_q && !ts_q[31];
  assign rem_sum = {1'b0, ts_rem_q} + {1'b0, wrap_inc_q};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_t_q <= 1'b0;
      ts_rem_q <= AVCA_RST_WORD;
    end else if (state_q == S_EVAL && ctrl_q[AVCA_VALID_BIT] &&
                 init_q && eval_pkt) begin
      seq_t_q <= ts_q[31];
      if (wrapped) begin
        ts_rem_q <= (rem_sum >= {21'h000000, modulus}) ?
                    rem_sum[31:0] - {20'h00000, modulus} :
                    rem_sum[31:0];
      end
    end else if (wr_fire && awaddr_q == AVCA_SEQ_STATE && wstrb_q[0]) begin
      seq_t_q <= wdata_q[0];
    end else if (wr_fire && awaddr_q == AVCA_TS_REM) begin
      ts_rem_q <= merge(ts_rem_q, wdata_q, wstrb_q);
    end
  end

  // Restoring divider of corrected timestamp by the interval
  assign div_tmp = {div_r_q, div_q[32]};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_r_q <= 8'h00;
      div_q <= 33'h0_0000_0000;
      div_cnt_q <= 6'h00;
    end else if (state_q == S_EVAL) begin
      div_r_q <= 8'h00;
      div_q <= {1'b0, ts_q} + {1'b0, wrapped ?
               ((rem_sum >= {21'h000000, modulus}) ?
                rem_sum[31:0] - {20'h00000, modulus} : rem_sum[31:0]) :
               ts_rem_q};
      div_cnt_q <= 6'h00;
    end else if (state_q == S_DIV && div_cnt_q != AVCA_DIV_STEPS) begin
      div_cnt_q <= div_cnt_q + 6'h01;
      if (div_tmp >= {1'b0, interval}) begin
        div_r_q <= div_tmp[7:0] - interval;
        div_q <= {div_q[31:0], 1'b1};
      end else begin
        div_r_q <= div_tmp[7:0];
        div_q <= {div_q[31:0], 1'b0};
      end
    end
  end

  // Frame and bearer walk
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_q <= 8'h00;
      bearer_q <= 8'h00;
    end else if (state_q == S_PKT) begin
      frame_q <= 8'h00;
      bearer_q <= 8'h00;
    end else if (smp_fire) begin
      if (last_b) begin
        bearer_q <= 8'h00;
        frame_q <= frame_q + 8'h01;
      end else begin
        bearer_q <= bearer_q + 8'h01;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pkt_count_q <= AVCA_RST_WORD;
    end else if (smp_fire && last_b && last_f) begin
      pkt_count_q <= pkt_count_q + 32'h0000_0001;
    end
  end

  // Packet descriptor
  assign seq_mask = (seqbits >= AVCA_MAX_SEQBITS) ? 4'hF :
                    4'((5'h01 << seqbits) - 5'h01);
  assign pkt_valid = state_q == S_PKT;
  assign pkt_samples = bearers * spp;
  assign pkt_uui_seq = div_q[3:0] & seq_mask;
  assign pkt_rate = rate_q;
  assign pkt_ss_enable = ss_ptr_q[15:0] != AVCA_RST_HALF;
  assign pkt_ss_addr = {ss_ptr_q[15:0], 5'h00};

  // Sample address in the bearer's circular buffer
  assign idx = (9'(next_byte_q) + {1'b0, frame_q}) & buf_mask(bufsz);
  assign base_eff = (bufsz == AVCA_BUF_512) ? {mem_rdata[15:1], 1'b0} :
                    mem_rdata;
  assign smp_valid = state_q == S_SMP;
  assign smp_addr = {base_eff, 9'h000} + {15'h0000, idx, 1'b0};
  assign smp_last = last_b && last_f;
endmodule : avca_channel_ctl

// [avca_channel_ctl_checker.sv]
// Port checker for the voice channel assembly control block.
// Assumes it is bound to avca_channel_ctl and sees only its ports.
`timescale 1ns/1ps
module avca_channel_ctl_checker (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Events
  input wire logic ev_valid,
  input wire logic ev_ready,
  // Packet descriptor
  input wire logic pkt_valid,
  input wire logic pkt_ready,
  input wire logic [15:0] pkt_samples,
  input wire logic [3:0] pkt_uui_seq,
  input wire logic [2:0] pkt_rate,
  input wire logic pkt_ss_enable,
  input wire logic [20:0] pkt_ss_addr,
  // Samples
  input wire logic smp_valid,
  input wire logic smp_ready,
  input wire logic [24:0] smp_addr,
  input wire logic smp_last
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire ev_take = ev_valid && ev_ready;
  wire smp_end = smp_valid && smp_ready && smp_last;
  pkt_hold_a: assert property (pkt_valid && !pkt_ready |=> pkt_valid &&
    $stable({pkt_samples, pkt_uui_seq, pkt_rate})) else $error("pkt lost");
  smp_hold_a: assert property (smp_valid && !smp_ready |=> smp_valid &&
    $stable({smp_addr, smp_last})) else $error("sample lost");
  ss_addr_a: assert property (pkt_valid |-> pkt_ss_addr[4:0] == 5'h00 &&
    pkt_ss_enable == (pkt_ss_addr != 21'h0)) else $error("ss address");
  rate_range_a: assert property (pkt_valid |-> pkt_rate <= 3'h4 &&
    pkt_samples != 16'h0000) else $error("bad rate or count");
  div_wait_a: assert property (ev_take |=> !pkt_valid [*8])
    else $error("packet too early");
  busy_pkt_a: assert property (pkt_valid || smp_valid |-> !ev_ready)
    else $error("idle while sending");
  smp_align_a: assert property (smp_valid |-> !smp_addr[0])
    else $error("odd sample address");
  last_idle_a: assert property (smp_end |=> !smp_valid ##[0:3] ev_ready)
    else $error("no idle after last");
  look_gap_a: assert property (pkt_valid && pkt_ready |=>
    !pkt_valid && !smp_valid) else $error("no look cycle");
  pkt_cov_c: cover property (pkt_valid && pkt_ready);
  last_cov_c: cover property (smp_end);
  start_cov_c: cover property (ev_take);
endmodule : avca_channel_ctl_checker
bind avca_channel_ctl avca_channel_ctl_checker avca_channel_ctl_checker_inst (
  .aclk, .aresetn, .ev_valid, .ev_ready, .pkt_valid, .pkt_ready,
  .pkt_samples, .pkt_uui_seq, .pkt_rate, .pkt_ss_enable, .pkt_ss_addr,
  .smp_valid, .smp_ready, .smp_addr, .smp_last);

// [avca_far_end.sv]
// Far-end model: CPS transmitter taking descriptors and samples.
// Assumes the bench selects prompt or slow answers through slow.
`timescale 1ns/1ps
module avca_far_end (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pace control
  input wire logic slow,
  // Ready outputs
  output logic pkt_ready,
  output logic smp_ready
);
  logic [1:0] pace_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pace_q <= 2'h0;
    end else begin
      pace_q <= pace_q + 2'h1;
    end
  end
  // Slow mode takes one beat in four
  assign pkt_ready = !slow || pace_q == 2'h0;
  assign smp_ready = !slow || pace_q == 2'h2;
endmodule : avca_far_end

// [tb_aal2_voice_channel_assembly_ctl.sv]
// Self-checking bench for the voice channel assembly control block.
// Assumes avca_pkg, the design, the far-end model and the checker.
`timescale 1ns/1ps
module tb_aal2_voice_channel_assembly_ctl import avca_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0, slow = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, lf, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0, ev_rate = 3'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, ev_valid = 1'b0;
  logic ev_start_indication = 1'b0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, ev_ready, pkt_valid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [15:0] tdm_wr_ptr = 16'h0, pkt_samples;
  logic [31:0] bus_timestamp = 32'h0;
  logic pkt_ready, pkt_ss_enable, smp_valid, smp_ready, smp_last;
  logic [3:0] pkt_uui_seq;
  logic [2:0] pkt_rate;
  logic [20:0] pkt_ss_addr;
  logic [24:0] smp_addr;
  logic [15:0] base [3];
  int failures = 0, total_checks = 0, nb, ival, sbits, bsz, npkt = 0;
  int spp [5] = '{1, 2, 3, 4, 2};
  logic [31:0] ts_or = 32'h0;
  longint rem_m = 0;
  logic msb_m = 1'b0;
  avca_channel_ctl avca_channel_ctl_inst (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .ev_valid, .ev_ready,
    .ev_start_indication, .ev_rate, .tdm_wr_ptr, .bus_timestamp,
    .pkt_valid, .pkt_ready, .pkt_samples, .pkt_uui_seq, .pkt_rate,
    .pkt_ss_enable, .pkt_ss_addr, .smp_valid, .smp_ready, .smp_addr,
    .smp_last);
  avca_far_end avca_far_end_inst (.aclk, .aresetn, .slow, .pkt_ready,
    .smp_ready);
  initial begin
    forever #2 aclk = ~aclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic wrap_up();
    $display("failures %0d total_checks %0d", failures, total_checks);
    if (failures == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Bounded wait step
  task automatic tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 300) begin
      failures++;
      wrap_up();
    end
  endtask : tick
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      tick(n);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", AVCA_RESP_OKAY, s_axi_bresp);
  endtask : wr
  task automatic rchk(input logic [11:0] a, input logic [31:0] e,
                      input logic [1:0] er);
    int n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      tick(n);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk("rdata", e, rd);
    chk("rresp", er, rs);
  endtask : rchk
  // One service event, then the packet it should or should not yield
  task automatic ev(input logic s, input logic [2:0] r, input int p,
                    input logic exp);
    int n = 0;
    int k = 0;
    logic [31:0] t;
    logic [15:0] bm;
    lf = lfsr(lf);
    t = (lf & 32'h7FFF_FFFF) | ts_or;
    @(posedge aclk);
    ev_valid <= 1'b1;
    ev_start_indication <= s;
    ev_rate <= r;
    tdm_wr_ptr <= p[15:0];
    bus_timestamp <= t;
    do tick(n); while (!ev_ready);
    ev_valid <= 1'b0;
    if (!exp) begin
      repeat (60) begin
        @(posedge aclk);
        if (pkt_valid) k++;
      end
      chk("no packet", 0, k);
    end else begin
      do tick(n); while (!(pkt_valid && pkt_ready));
      chk("samples", 3 * spp[r], pkt_samples);
      chk("rate", r, pkt_rate);
      if (msb_m && !t[31]) begin
        rem_m = (rem_m + 64'h1_0000_0000 % (ival * 16)) % (ival * 16);
      end
      msb_m = t[31];
      k = 32'(((t + rem_m) / ival) % (1 << sbits));
      chk("uui", k, pkt_uui_seq);
      chk("ss addr", 32'h0000_00A0, pkt_ss_addr);
      chk("ss enable", 1, pkt_ss_enable);
      for (int f = 0; f < spp[r]; f++) begin
        for (int b = 0; b < 3; b++) begin
          do tick(n); while (!(smp_valid && smp_ready));
          bm = bsz ? base[b] & 16'hFFFE : base[b];
          k = (nb + f) % (bsz ? 512 : 256);
          chk("smp addr", {bm, 9'h000} + 2 * k, smp_addr);
          chk("last", f == spp[r] - 1 && b == 2, smp_last);
        end
      end
      nb += spp[r];
      npkt++;
    end
  endtask : ev
  initial begin
    lf = 32'h0000_0020;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(AVCA_CTRL, 32'h0, AVCA_RESP_OKAY);
    rchk(AVCA_PKT_COUNT, 32'h0, AVCA_RESP_OKAY);
    rchk(12'h300, 32'h0, AVCA_RESP_SLVERR);
    for (int i = 0; i < 3; i++) begin
      lf = lfsr(lf);
      base[i] = lf[15:0];
      wr(AVCA_BEARER_BASE + 12'(4 * i), {16'h0000, base[i]});
    end
    wr(AVCA_SPP_LO, {8'(spp[3]), 8'(spp[2]), 8'(spp[1]), 8'(spp[0])});
    wr(AVCA_SS_PTR, 32'h0000_0005);
    wr(AVCA_NEXT_BYTE, 32'h0000_0002);
    wr(AVCA_TS_OFFSET, 32'h0);
    wr(AVCA_SEQ_STATE, 32'h0);
    wr(AVCA_TS_REM, 32'h0);
    wr(AVCA_CTRL, 32'h0003_0000);
    ival = 40;
    sbits = 3;
    bsz = 0;
    ev(1'b1, 3'h0, 10, 1'b0);
    rchk(AVCA_CTRL, 32'h0003_0000, AVCA_RESP_OKAY);
    wr(AVCA_CTRL, 32'h0003_0001);
    ev(1'b1, 3'h0, 10, 1'b0);
    nb = 12;
    rchk(AVCA_NEXT_BYTE, 32'd12, AVCA_RESP_OKAY);
    rchk(AVCA_CTRL, 32'h0003_0003, AVCA_RESP_OKAY);
    wr(AVCA_SEQ_CFG, {8'h00, 8'd40, 5'h00, 3'h3, 8'h02});
    ev(1'b0, 3'h0, 11, 1'b0); // Pointer below next byte
    for (int r = 0; r < 5; r++) begin
      ival = r == 0 ? 1 : (r == 4 ? 255 : 40);
      sbits = r;
      slow <= r[0];
      wr(AVCA_SEQ_CFG, {8'h00, 8'(ival), 5'h00, 3'(r), 8'(spp[4])});
      wr(AVCA_WRAP_INC, 32'(64'h1_0000_0000 % (ival * 16)));
      ev(1'b0, 3'(r), nb + 3, 1'b1);
    end
    ev(1'b0, 3'h5, nb + 3, 1'b0);
    rchk(AVCA_PKT_COUNT, 32'(npkt), AVCA_RESP_OKAY);
    rchk(AVCA_NEXT_BYTE, 32'(nb), AVCA_RESP_OKAY);
    for (int b = 0; b < 2; b++) begin
      bsz = b;
      nb = b ? 510 : 254;
      ts_or = b ? 32'h0 : 32'h8000_0000;
      wr(AVCA_CTRL, 32'h0003_0002 | 32'(b << 8));
      wr(AVCA_NEXT_BYTE, 32'(nb));
      wr(AVCA_CTRL, 32'h0003_0003 | 32'(b << 8));
      ev(1'b0, 3'h2, nb + 3, 1'b1);
    end
    rchk(AVCA_TS_REM, 32'(rem_m), AVCA_RESP_OKAY);
    wrap_up();
  end
endmodule : tb_aal2_voice_channel_assembly_ctl
